// *** rtl/dcia_chain.sv ***
// Fixed six-level internal priority chain
`timescale 1ns/100ps
`include "dcia_defines.svh"
module dcia_chain (
    dcia_chain_if.chain ch
);
    import dcia_pkg::*;

    // Ripple from level 0 downward; a serviced level blocks all below
    always_comb begin
        logic blocked;
        logic svc_above;
        blocked   = 1'b0;
        svc_above = 1'b0;
        ch.req    = '0;
        ch.active = '0;
        ch.hold   = 1'b0;
        for (int i = 0; i < `DCIA_NUM_LEVELS; i++) begin
            // Return targets the top serviced level, pending ones aside
            if (!svc_above && ch.ius[i]) begin
                ch.active[i] = 1'b1;
            end
            // Request ripple ignores the prefix, so one winner only
            if (!blocked && ch.pending[i] && !ch.ius[i]) begin
                ch.req[i] = 1'b1;
            end
            if (ch.ius[i]) begin
                svc_above = 1'b1;
            end
            if (ch.ius[i] || ch.pending[i]) begin
                blocked = 1'b1;
            end
            // Prefix seen: only serviced levels keep the chain low
            if (ch.ius[i] || (ch.pending[i] && !ch.prefix_mode)) begin
                ch.hold = 1'b1;
            end
        end
    end
endmodule : dcia_chain

// *** rtl/dcia_chain_if.sv ***
// Signals between the controller and its internal priority chain
`timescale 1ns/100ps
interface dcia_chain_if;
    import dcia_pkg::*;
    dcia_lvl_t pending;
    dcia_lvl_t ius;
    logic      prefix_mode;
    dcia_lvl_t req;
    dcia_lvl_t active;
    logic      hold;

    modport chain (input pending, input ius, input prefix_mode,
                   output req, output active, output hold);
    modport ctl (output pending, output ius, output prefix_mode,
                 input req, input active, input hold);
endinterface : dcia_chain_if

// *** rtl/dcia_defines.svh ***
// Constants for the daisy-chain interrupt acknowledge block
`ifndef DCIA_DEFINES_SVH
`define DCIA_DEFINES_SVH
`define DCIA_NUM_LEVELS 6
`define DCIA_OP_PREFIX  8'hed
`define DCIA_OP_RETURN  8'h4d
`define DCIA_VEC_IDLE   3'h3
`define DCIA_VEC_LSB    1
`define DCIA_VEC_MSB    3
`define DCIA_RST_BYTE   8'h00
`define DCIA_RST_LEVELS 6'h00
`endif

// *** rtl/dcia_pkg.sv ***
// Types and helpers shared by the interrupt chain modules
package dcia_pkg;
    `include "dcia_defines.svh"

    typedef logic [`DCIA_NUM_LEVELS-1:0] dcia_lvl_t;
    typedef logic [7:0]                  dcia_byte_t;

    // Index of the single set bit, level 0 being the highest
    function automatic logic [2:0] dcia_code(input dcia_lvl_t onehot);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < `DCIA_NUM_LEVELS; i++) begin
            if (onehot[i]) begin
                c = 3'(i);
            end
        end
        return c;
    endfunction : dcia_code
endpackage : dcia_pkg

// *** rtl/dcia_top.sv ***
// Daisy-chain interrupt request, acknowledge and return logic
`timescale 1ns/100ps
`include "dcia_defines.svh"
module dcia_top #(
    parameter int NUM_LEVELS = `DCIA_NUM_LEVELS
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             fetch_cycle_n,
    input  wire logic             io_request_n,
    input  wire logic             chain_enable_in,
    input  wire dcia_pkg::dcia_byte_t data_in,
    input  wire dcia_pkg::dcia_lvl_t  src_req,
    input  wire dcia_pkg::dcia_lvl_t  src_enable,
    input  wire dcia_pkg::dcia_byte_t vector_base,
    input  wire logic             status_affects_vector,
    input  wire logic             sw_return,
    output logic                  int_req_n,
    output logic                  chain_enable_out,
    output dcia_pkg::dcia_byte_t  data_out,
    output logic                  data_oe_n,
    output dcia_pkg::dcia_lvl_t   under_service
);
    import dcia_pkg::*;

    typedef struct packed {
        dcia_lvl_t  pending;
        dcia_lvl_t  ius;
        logic       prefix_seen;
        dcia_byte_t fetch_byte;
        logic       in_fetch;
        logic       in_ack;
        logic       int_n;
        logic       chain_out;
        dcia_byte_t vec;
        logic       oe_n;
    } dcia_state_t;

    dcia_state_t s_q;
    dcia_state_t s_d;
    dcia_chain_if ch ();

    logic opcode_cycle;
    logic ack_cycle;
    logic ack_start;
    logic fetch_end;
    logic ret_match;
    dcia_byte_t vec_now;

    dcia_chain u_chain (
        .ch (ch)
    );

    // Feed the chain from the registered state
    assign ch.pending     = s_q.pending;
    assign ch.ius         = s_q.ius;
    assign ch.prefix_mode = s_q.prefix_seen;

    // Cycle classification from the host strobes
    assign opcode_cycle = !fetch_cycle_n && io_request_n;
    assign ack_cycle    = !fetch_cycle_n && !io_request_n;
    assign ack_start    = ack_cycle && !s_q.in_ack;
    assign fetch_end    = fetch_cycle_n && s_q.in_fetch;
    // Only the level inside the chain window answers the return byte
    assign ret_match = fetch_end && s_q.prefix_seen
                       && s_q.fetch_byte == `DCIA_OP_RETURN
                       && chain_enable_in && |ch.active;

    // Vector with optional status code in bits 3..1
    always_comb begin
        vec_now = vector_base;
        if (status_affects_vector) begin
            if (|ch.req) begin
                vec_now[`DCIA_VEC_MSB:`DCIA_VEC_LSB] = dcia_code(ch.req);
            end else begin
                vec_now[`DCIA_VEC_MSB:`DCIA_VEC_LSB] = `DCIA_VEC_IDLE;
            end
        end
    end

    // Next-state logic
    always_comb begin
        s_d = s_q;
        // Status frozen during fetch so the chain ripple settles
        if (fetch_cycle_n) begin
            s_d.pending = src_req & src_enable;
        end
        // Opcode byte tracking
        if (opcode_cycle) begin
            s_d.in_fetch   = 1'b1;
            s_d.fetch_byte = data_in;
        end else if (fetch_cycle_n) begin
            s_d.in_fetch = 1'b0;
        end
        if (!fetch_cycle_n && !io_request_n) begin
            s_d.in_fetch = 1'b0;
        end
        if (fetch_end) begin
            s_d.prefix_seen = (s_q.fetch_byte == `DCIA_OP_PREFIX);
        end
        // Return clears only the highest serviced level
        if (ret_match || sw_return) begin
            s_d.ius = s_q.ius & ~ch.active;
        end
        // Acknowledge: winner drives vector and enters service
        s_d.in_ack = ack_cycle;
        if (ack_start && chain_enable_in && |ch.req) begin
            s_d.ius  = s_d.ius | ch.req;
            s_d.vec  = vec_now;
            s_d.oe_n = 1'b0;
        end else if (!ack_cycle) begin
            s_d.oe_n = 1'b1;
            s_d.vec  = vec_now;
        end
        s_d.int_n = !(|ch.req);
        s_d.chain_out = chain_enable_in && !ch.hold;
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '{pending:     `DCIA_RST_LEVELS,
                     ius:         `DCIA_RST_LEVELS,
                     prefix_seen: 1'b0,
                     fetch_byte:  `DCIA_RST_BYTE,
                     in_fetch:    1'b0,
                     in_ack:      1'b0,
                     int_n:       1'b1,
                     chain_out:   1'b0,
                     vec:         `DCIA_RST_BYTE,
                     oe_n:        1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state flops
    assign int_req_n        = s_q.int_n;
    assign chain_enable_out = s_q.chain_out;
    assign data_out         = s_q.vec;
    assign data_oe_n        = s_q.oe_n;
    assign under_service    = s_q.ius;

    // Checks
    sequence s_ack_win;
        ack_start && chain_enable_in && |ch.req;
    endsequence

    sequence s_ret_pair;
        ret_match && !ack_cycle;
    endsequence

    property p_int_req;
        @(posedge core_clk) disable iff (rst)
        |ch.req |=> !int_req_n;
    endproperty
    a_int_req: assert property (p_int_req)
        else $error("request line not low with pending level");

    property p_pass;
        @(posedge core_clk) disable iff (rst)
        !(|(s_q.pending | s_q.ius))
        |=> chain_enable_out == $past(chain_enable_in);
    endproperty
    a_pass: assert property (p_pass)
        else $error("idle chain output differs from input");

    property p_force_low;
        @(posedge core_clk) disable iff (rst)
        |s_q.ius |=> !chain_enable_out;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("chain output high while a level in service");

    property p_freeze;
        @(posedge core_clk) disable iff (rst)
        !fetch_cycle_n |=> s_q.pending == $past(s_q.pending);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("pending status changed during fetch");

    property p_ack;
        @(posedge core_clk) disable iff (rst)
        s_ack_win |=> !data_oe_n && (|(under_service & ~$past(s_q.ius)))
                      && data_out == $past(vec_now);
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge winner did not drive vector");

    property p_one_winner;
        @(posedge core_clk) disable iff (rst)
        s_ack_win |=> $onehot(under_service & ~$past(s_q.ius));
    endproperty
    a_one_winner: assert property (p_one_winner)
        else $error("acknowledge entered more than one level");

    property p_prefix;
        @(posedge core_clk) disable iff (rst)
        s_q.prefix_seen && !(|s_q.ius)
        |=> chain_enable_out == $past(chain_enable_in);
    endproperty
    a_prefix: assert property (p_prefix)
        else $error("pending level held chain low after prefix");

    property p_ret;
        @(posedge core_clk) disable iff (rst)
        s_ret_pair |=> $countones(s_q.ius) == $countones($past(s_q.ius)) - 1;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return byte pair did not clear one latch");

    property p_sw_ret;
        @(posedge core_clk) disable iff (rst)
        sw_return && |s_q.ius && !ack_cycle
        |=> $countones(s_q.ius) == $countones($past(s_q.ius)) - 1;
    endproperty
    a_sw_ret: assert property (p_sw_ret)
        else $error("software return did not clear exactly one latch");

    property p_idle_vec;
        @(posedge core_clk) disable iff (rst)
        status_affects_vector && !(|ch.req) && !ack_cycle
        |=> data_out[`DCIA_VEC_MSB:`DCIA_VEC_LSB] == `DCIA_VEC_IDLE;
    endproperty
    a_idle_vec: assert property (p_idle_vec)
        else $error("idle status vector code wrong");
endmodule : dcia_top

// *** sim/daisy_chain_interrupt_ack_test.sv ***
// Self-checking bench for the daisy-chain interrupt block
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module daisy_chain_interrupt_ack_test;
    import dcia_pkg::*;
    logic       core_clk, rst, chain_enable_in, status_affects_vector;
    logic       sw_return, fetch_cycle_n, io_request_n;
    logic       int_req_n, chain_enable_out, data_oe_n;
    dcia_byte_t data_in, vector_base, data_out;
    dcia_lvl_t  src_req, src_enable, under_service, hi;
    int         errors, samples_checked, cycles, l;

    dcia_top dut (.core_clk, .rst, .fetch_cycle_n, .io_request_n,
        .chain_enable_in, .data_in, .src_req, .src_enable, .vector_base,
        .status_affects_vector, .sw_return, .int_req_n, .chain_enable_out,
        .data_out, .data_oe_n, .under_service);
    dcia_host host (.core_clk, .fetch_cycle_n, .io_request_n, .data_in);

    // Free-running clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // Vector with level code in bits 3..1; code 011 when idle
    function automatic dcia_byte_t exp_vec(dcia_byte_t b, logic s, int v);
        if (!s) return b;
        return {b[7:4], (v < 0) ? 3'h3 : 3'(v), b[0]};
    endfunction : exp_vec
    // Request set, seen two edges later
    task automatic raise(input dcia_lvl_t m);
        src_req = m;
        repeat (2) @(negedge core_clk);
        `CHK(int_req_n, 1'b0)
        `CHK(chain_enable_out, 1'b0)
    endtask : raise
    // Source drops its request once served
    task automatic do_ack(input int v, input dcia_lvl_t us);
        host.ack_start();
        `CHK(data_oe_n, 1'b0)
        `CHK(data_out, exp_vec(vector_base, status_affects_vector, v))
        `CHK(under_service, us)
        host.ack_end();
        src_req = 6'h00;
    endtask : do_ack
    task automatic do_ret(input bit sw, input dcia_lvl_t us);
        if (sw) begin
            @(negedge core_clk);
            sw_return = 1'b1;
            @(negedge core_clk);
            sw_return = 1'b0;
        end else begin
            host.fetch(8'hed);
            host.fetch(8'h4d);
        end
        repeat (2) @(negedge core_clk);
        `CHK(under_service, us)
        `CHK(data_oe_n, 1'b1)
    endtask : do_ret

    // Main sequence
    initial begin
        rst = 1'b1;
        chain_enable_in = 1'b1;
        status_affects_vector = 1'b0;
        sw_return = 1'b0;
        src_req = 6'h00;
        src_enable = 6'h00;
        vector_base = 8'h00;
        void'($urandom(56404));
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        `CHK(int_req_n, 1'b1)
        `CHK(under_service, 6'h00)
        // Idle chain passes its input through
        chain_enable_in = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK(chain_enable_out, 1'b0)
        chain_enable_in = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK(chain_enable_out, 1'b1)
        // Disabled requests stay silent
        src_req = 6'h3f;
        repeat (3) @(negedge core_clk);
        `CHK(int_req_n, 1'b1)
        // Random mixes; higher levels present but disabled
        for (int i = 0; i < 24; i++) begin
            l = $urandom % 6;
            hi = 6'((1 << l) - 1);
            src_enable = (6'($urandom) & ~hi) | 6'(1 << l);
            vector_base = 8'($urandom);
            status_affects_vector = 1'($urandom);
            raise(6'($urandom << (l + 1)) | 6'(1 << l)
                  | (6'($urandom) & hi));
            do_ack(l, 6'(1 << l));
            do_ret(1'($urandom), 6'h00);
        end
        // Idle vector code
        status_affects_vector = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK(data_out, exp_vec(vector_base, 1'b1, -1))
        // Level 0 request nests over level 4 in service
        src_enable = 6'h3f;
        raise(6'h10);
        do_ack(4, 6'h10);
        raise(6'h01);
        do_ack(0, 6'h11);
        // Return pair ignored while the chain input is low
        chain_enable_in = 1'b0;
        do_ret(1'b0, 6'h11);
        chain_enable_in = 1'b1;
        do_ret(1'b0, 6'h10);
        do_ret(1'b1, 6'h00);
        `CHK(chain_enable_out, 1'b1)
        // Prefix byte lets a pending, unserved level free the chain
        raise(6'h04);
        host.fetch(8'hed);
        repeat (2) @(negedge core_clk);
        `CHK(chain_enable_out, 1'b1)
        `CHK(int_req_n, 1'b0)
        host.fetch(8'h00);
        repeat (2) @(negedge core_clk);
        `CHK(chain_enable_out, 1'b0)
        src_req = 6'h00;
        repeat (2) @(negedge core_clk);
        `CHK(chain_enable_out, 1'b1)
        print_verdict();
    end
endmodule : daisy_chain_interrupt_ack_test

// *** sim/dcia_host.sv ***
// Host processor model: acknowledge strobes and opcode fetches
`timescale 1ns/100ps
module dcia_host (
    input  wire logic            core_clk,
    output logic                 fetch_cycle_n,
    output logic                 io_request_n,
    output dcia_pkg::dcia_byte_t data_in
);
    import dcia_pkg::*;
    // Idle bus with strobes high
    initial begin
        fetch_cycle_n = 1'b1;
        io_request_n  = 1'b1;
        data_in       = 8'h5a;
    end
    // Both strobes low together, held over two edges
    task automatic ack_start();
        @(negedge core_clk);
        fetch_cycle_n = 1'b0;
        io_request_n  = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : ack_start
    // Released together at once, with no wait for a clock edge
    task automatic ack_end();
        fetch_cycle_n = 1'b1;
        io_request_n  = 1'b1;
    endtask : ack_end
    // Opcode fetch; released bus shows the inverse, never the old byte
    task automatic fetch(input dcia_byte_t b);
        @(negedge core_clk);
        fetch_cycle_n = 1'b0;
        data_in       = b;
        @(negedge core_clk);
        fetch_cycle_n = 1'b1;
        data_in       = ~b;
    endtask : fetch
endmodule : dcia_host
